// >>> hw/spmc_top.sv
// Serial port with flow control, DMA requests, smartcard, half-duplex and infrared modes.
// Assumes register strobes on the clock domain; line and handshake pins are asynchronous.
//
// Function
// - Clear-to-send change raises interrupt when enabled
// - Transmit starts only while clear-to-send input low
// - Clear-to-send loss finishes current character first
// - Data written without clear-to-send waits
// - Request-to-send low only when receiver free
// - Control bit 7 enables transmit DMA requests
// - Control bit 6 enables receive DMA requests
// - Control bit 5 selects smartcard operation
// - Smartcard parity error sends negative acknowledge
// - Control bit 3 selects single-wire half duplex
// - Bit 1 infrared, bit 2 low-power variant
// - Error interrupt only with receive DMA
// - Smartcard guard time delays transmit complete
// - Low-power infrared divides by prescaler value
// - Smartcard clock divides by twice prescaler bits 4 to 0
// - Upper guard/prescaler half reads zero
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps

module spmc_top
	import spmc_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	input wire logic rx_pin_in,
	input wire logic tx_pin_in,
	output logic tx_pin_out,
	output logic tx_pin_oe_n,
	input wire logic clear_to_send_in_n,
	output logic request_to_send_out_n,
	output logic smartcard_clk_out,
	output logic tx_dma_req,
	output logic rx_dma_req,
	output logic irq
);

	// ****************************************
	// Decoding helper
	// ****************************************
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
		addr_hit = (addr == off);
	endfunction

	// ****************************************
	// Registers
	// ****************************************
	logic [SPMC_C1_W-1:0] ctrl1_reg;
	logic [SPMC_C2_W-1:0] ctrl2_reg;
	spmc_ctrl3_type ctrl3_reg;
	spmc_gtpr_type gtpr_reg;
	logic [15:0] baud_reg;
	logic [SPMC_ST_W-1:0] mask_reg;
	logic [SPMC_ST_W-1:0] status_reg;
	logic [SPMC_ST_W-1:0] status_next;
	logic [7:0] tx_buf_reg;
	logic tx_full_reg;
	logic [7:0] rx_data_reg;

	wire wr_status = reg_write & addr_hit(reg_addr, SPMC_OFF_STATUS);
	wire wr_data = reg_write & addr_hit(reg_addr, SPMC_OFF_DATA);
	wire wr_baud = reg_write & addr_hit(reg_addr, SPMC_OFF_BAUD);
	wire wr_ctrl1 = reg_write & addr_hit(reg_addr, SPMC_OFF_CTRL1);
	wire wr_ctrl2 = reg_write & addr_hit(reg_addr, SPMC_OFF_CTRL2);
	wire wr_ctrl3 = reg_write & addr_hit(reg_addr, SPMC_OFF_CTRL3);
	wire wr_gtpr = reg_write & addr_hit(reg_addr, SPMC_OFF_GTPR);
	wire wr_mask = reg_write & addr_hit(reg_addr, SPMC_OFF_MASK);
	wire rd_data = reg_read & addr_hit(reg_addr, SPMC_OFF_DATA);

	wire uart_en = ctrl1_reg[SPMC_C1_UE];
	wire par_en = ctrl1_reg[SPMC_C1_PCE];
	wire par_odd = ctrl1_reg[SPMC_C1_PS];
	wire tx_en = ctrl1_reg[SPMC_C1_TE] & uart_en;
	wire rx_en = ctrl1_reg[SPMC_C1_RE] & uart_en;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] sync1_reg;
	logic [2:0] sync2_reg;
	logic cts_prev_reg;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= 3'h7;
			sync2_reg <= 3'h7;
			cts_prev_reg <= 1'b1;
		end else begin
			sync1_reg <= {clear_to_send_in_n, tx_pin_in, rx_pin_in};
			sync2_reg <= sync1_reg;
			cts_prev_reg <= sync2_reg[2];
		end
	end

	wire cts_n = sync2_reg[2];
	wire one_wire = ctrl3_reg.half_duplex_sel | ctrl3_reg.smartcard_en;
	wire rx_line = one_wire ? sync2_reg[1] : sync2_reg[0];
	wire cts_change = ctrl3_reg.clear_to_send_flow_en & (cts_n != cts_prev_reg);
	wire cts_ok = ~ctrl3_reg.clear_to_send_flow_en | ~cts_n;

	// ****************************************
	// Bit timing
	// ****************************************
	wire [15:0] bit_div = (baud_reg == 16'h0000) ? 16'h0001 : baud_reg;
	wire [15:0] half_div = {1'b0, bit_div[15:1]};
	wire [17:0] ir_norm_len = (({2'b00, bit_div} * SPMC_IR_PULSE_NUM) >> SPMC_IR_PULSE_SHIFT);
	wire [17:0] ir_lp_len = {10'h000, gtpr_reg.clock_prescale} * SPMC_IR_PULSE_NUM;
	wire [17:0] ir_len = ctrl3_reg.infrared_low_power ? ir_lp_len : ir_norm_len;

	// ****************************************
	// Transmitter
	// ****************************************
	spmc_tx_state_type tx_state_reg;
	spmc_tx_state_type tx_state_next;
	logic [15:0] tx_cnt_reg;
	logic [7:0] tx_bits_reg;
	logic [7:0] tx_shift_reg;
	logic tx_par_reg;

	wire tx_tick = (tx_cnt_reg == bit_div - 16'h0001);
	// start only with data and permission
	wire tx_load = (tx_state_reg == SPMC_TX_IDLE) & tx_full_reg & tx_en & cts_ok;
	wire tx_last_data = (tx_bits_reg == 8'(SPMC_DATA_BITS - 1));
	wire guard_needed = ctrl3_reg.smartcard_en & (gtpr_reg.guard_time != 8'h00);
	wire tx_stop_done = (tx_state_reg == SPMC_TX_STOP) & tx_tick;
	wire guard_done = (tx_state_reg == SPMC_TX_GUARD) & tx_tick &
		(tx_bits_reg == gtpr_reg.guard_time - 8'h01);
	// complete flag after the guard time
	wire tc_set = (tx_stop_done & ~guard_needed) | guard_done;

	always_comb begin
		tx_state_next = tx_state_reg;
		unique case (tx_state_reg)
			SPMC_TX_IDLE: begin
				if (tx_load) begin
					tx_state_next = SPMC_TX_START;
				end
			end
			SPMC_TX_START: begin
				if (tx_tick) begin
					tx_state_next = SPMC_TX_DATA;
				end
			end
			SPMC_TX_DATA: begin
				if (tx_tick && tx_last_data) begin
					tx_state_next = par_en ? SPMC_TX_PAR : SPMC_TX_STOP;
				end
			end
			SPMC_TX_PAR: begin
				if (tx_tick) begin
					tx_state_next = SPMC_TX_STOP;
				end
			end
			// the frame runs on to its stop bit regardless of clear-to-send
			SPMC_TX_STOP: begin
				if (tx_tick) begin
					tx_state_next = guard_needed ? SPMC_TX_GUARD : SPMC_TX_IDLE;
				end
			end
			SPMC_TX_GUARD: begin
				if (guard_done) begin
					tx_state_next = SPMC_TX_IDLE;
				end
			end
			default: begin
				tx_state_next = SPMC_TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tx_state_reg <= SPMC_TX_IDLE;
			tx_cnt_reg <= 16'h0000;
			tx_bits_reg <= 8'h00;
			tx_shift_reg <= 8'h00;
			tx_par_reg <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_cnt_reg <= (tx_load || tx_tick) ? 16'h0000 : tx_cnt_reg + 16'h0001;
			if (tx_load) begin
				tx_shift_reg <= tx_buf_reg;
				tx_par_reg <= ^tx_buf_reg ^ par_odd;
				tx_bits_reg <= 8'h00;
			end else if (tx_tick && (tx_state_reg == SPMC_TX_DATA)) begin
				tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
				tx_bits_reg <= tx_last_data ? 8'h00 : tx_bits_reg + 8'h01;
			end else if (tx_tick && (tx_state_reg == SPMC_TX_GUARD)) begin
				tx_bits_reg <= tx_bits_reg + 8'h01;
			end
		end
	end

	wire tx_bit = (tx_state_reg == SPMC_TX_START) ? 1'b0 :
		(tx_state_reg == SPMC_TX_DATA) ? tx_shift_reg[0] :
		(tx_state_reg == SPMC_TX_PAR) ? tx_par_reg : 1'b1;
	wire tx_active = (tx_state_reg != SPMC_TX_IDLE) & (tx_state_reg != SPMC_TX_GUARD);

	// ****************************************
	// Receiver
	// ****************************************
	spmc_rx_state_type rx_state_reg;
	spmc_rx_state_type rx_state_next;
	logic [15:0] rx_cnt_reg;
	logic [7:0] rx_bits_reg;
	logic [7:0] rx_shift_reg;
	logic rx_low_seen_reg;
	logic rx_prev_reg;
	logic rx_perr_reg;
	logic rx_noise_reg;

	wire rx_tick = (rx_cnt_reg == 16'h0000) & (rx_state_reg != SPMC_RX_IDLE);
	// infrared reception takes any pulse in the bit as zero
	wire rx_sample = ctrl3_reg.infrared_en ? ~(rx_low_seen_reg | ~rx_line) : rx_line;
	wire rx_begin = (rx_state_reg == SPMC_RX_IDLE) & rx_en & ~rx_line;
	wire rx_last_data = (rx_bits_reg == 8'(SPMC_DATA_BITS - 1));
	wire [7:0] rx_word = {rx_sample, rx_shift_reg[7:1]};
	wire rx_stop = (rx_state_reg == SPMC_RX_STOP) & rx_tick;
	wire par_bad = rx_stop & rx_perr_reg;
	// answer a parity error on the line
	wire nak_go = par_bad & ctrl3_reg.smartcard_en & ctrl3_reg.parity_nak_en;
	wire rx_done = rx_stop & ~status_reg[SPMC_ST_RXNE];
	wire rx_overrun = rx_stop & status_reg[SPMC_ST_RXNE];
	wire rx_noisy = rx_tick & (rx_line != rx_prev_reg) & ~ctrl3_reg.infrared_en;

	always_comb begin
		rx_state_next = rx_state_reg;
		unique case (rx_state_reg)
			SPMC_RX_IDLE: begin
				if (rx_begin) begin
					rx_state_next = SPMC_RX_START;
				end
			end
			SPMC_RX_START: begin
				if (rx_tick) begin
					rx_state_next = rx_sample ? SPMC_RX_IDLE : SPMC_RX_DATA;
				end
			end
			SPMC_RX_DATA: begin
				if (rx_tick && rx_last_data) begin
					rx_state_next = par_en ? SPMC_RX_PAR : SPMC_RX_STOP;
				end
			end
			SPMC_RX_PAR: begin
				if (rx_tick) begin
					rx_state_next = SPMC_RX_STOP;
				end
			end
			SPMC_RX_STOP: begin
				if (rx_tick) begin
					rx_state_next = nak_go ? SPMC_RX_NAK : SPMC_RX_IDLE;
				end
			end
			SPMC_RX_NAK: begin
				if (rx_tick) begin
					rx_state_next = SPMC_RX_IDLE;
				end
			end
			default: begin
				rx_state_next = SPMC_RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rx_state_reg <= SPMC_RX_IDLE;
			rx_cnt_reg <= 16'h0000;
			rx_bits_reg <= 8'h00;
			rx_shift_reg <= 8'h00;
			rx_low_seen_reg <= 1'b0;
			rx_prev_reg <= 1'b1;
			rx_perr_reg <= 1'b0;
			rx_noise_reg <= 1'b0;
		end else begin
			rx_state_reg <= rx_state_next;
			rx_prev_reg <= rx_line;
			rx_low_seen_reg <= rx_tick ? 1'b0 : (rx_low_seen_reg | ~rx_line);
			if (rx_begin) begin
				rx_cnt_reg <= half_div;
				rx_bits_reg <= 8'h00;
				rx_perr_reg <= 1'b0;
				rx_noise_reg <= 1'b0;
			end else if (rx_tick) begin
				rx_cnt_reg <= bit_div - 16'h0001;
				rx_noise_reg <= rx_noise_reg | rx_noisy;
			end else if (rx_state_reg != SPMC_RX_IDLE) begin
				rx_cnt_reg <= rx_cnt_reg - 16'h0001;
			end
			if (rx_tick && (rx_state_reg == SPMC_RX_DATA)) begin
				rx_shift_reg <= rx_word;
				rx_bits_reg <= rx_bits_reg + 8'h01;
			end
			if (rx_tick && (rx_state_reg == SPMC_RX_PAR)) begin
				rx_perr_reg <= (^rx_shift_reg ^ par_odd) != rx_sample;
			end
		end
	end

	// ****************************************
	// Line driver
	// ****************************************
	wire nak_drive = (rx_state_reg == SPMC_RX_NAK);
	wire line_bit = tx_bit & ~nak_drive;
	wire ir_pulse = ~line_bit & ({2'b00, tx_cnt_reg} < ir_len);
	// infrared encodes zeros as short pulses
	wire pin_level = ctrl3_reg.infrared_en ? ir_pulse : line_bit;
	// one-wire modes release the pin when idle
	wire pin_oe_n = ctrl3_reg.smartcard_en ? line_bit :
		ctrl3_reg.half_duplex_sel ? ~(tx_active | nak_drive) : 1'b0;

	// ****************************************
	// Smartcard clock
	// ****************************************
	logic [4:0] sc_cnt_reg;
	logic sc_clk_reg;
	wire [4:0] sc_div = gtpr_reg.clock_prescale[4:0];
	// toggle every prescaler count, bits 7 to 5 ignored
	wire sc_flip = ctrl3_reg.smartcard_en & (sc_div != 5'h00) & (sc_cnt_reg == sc_div - 5'h01);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			sc_cnt_reg <= 5'h00;
			sc_clk_reg <= 1'b0;
		end else begin
			sc_cnt_reg <= (sc_flip || !ctrl3_reg.smartcard_en) ? 5'h00 : sc_cnt_reg + 5'h01;
			sc_clk_reg <= ctrl3_reg.smartcard_en & (sc_clk_reg ^ sc_flip);
		end
	end

	// ****************************************
	// Status, control and data registers
	// ****************************************
	logic [SPMC_ST_W-1:0] st_set;
	always_comb begin
		st_set = '0;
		st_set[SPMC_ST_CTS] = cts_change;
		st_set[SPMC_ST_TC] = tc_set;
		st_set[SPMC_ST_RXNE] = rx_done;
		st_set[SPMC_ST_ORE] = rx_overrun;
		st_set[SPMC_ST_NE] = rx_stop & rx_noise_reg;
		st_set[SPMC_ST_FE] = rx_stop & ~rx_sample;
		st_set[SPMC_ST_PE] = par_bad;
		status_next = status_reg;
		if (wr_status) begin
			status_next = status_reg & ~reg_wdata[SPMC_ST_W-1:0];
		end
		if (rd_data) begin
			status_next[SPMC_ST_RXNE] = 1'b0;
		end
		status_next[SPMC_ST_TXE] = 1'b0;
		status_next = status_next | st_set;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			status_reg <= SPMC_STATUS_RST;
			ctrl1_reg <= '0;
			ctrl2_reg <= '0;
			ctrl3_reg <= '0;
			gtpr_reg <= SPMC_GTPR_RST;
			baud_reg <= 16'h0000;
			mask_reg <= '0;
			tx_buf_reg <= 8'h00;
			tx_full_reg <= 1'b0;
			rx_data_reg <= 8'h00;
		end else begin
			status_reg <= status_next;
			if (wr_ctrl1) begin
				ctrl1_reg <= reg_wdata[SPMC_C1_W-1:0];
			end
			if (wr_ctrl2) begin
				ctrl2_reg <= reg_wdata[SPMC_C2_W-1:0];
			end
			if (wr_ctrl3) begin
				ctrl3_reg <= spmc_ctrl3_type'(reg_wdata[SPMC_C3_W-1:0]);
			end
			// only the low half is stored
			if (wr_gtpr) begin
				gtpr_reg <= spmc_gtpr_type'(reg_wdata[15:0]);
			end
			if (wr_baud) begin
				baud_reg <= reg_wdata[15:0];
			end
			if (wr_mask) begin
				mask_reg <= reg_wdata[SPMC_ST_W-1:0];
			end
			// a written word waits in the buffer
			if (wr_data) begin
				tx_buf_reg <= reg_wdata[7:0];
				tx_full_reg <= 1'b1;
			end else if (tx_load) begin
				tx_full_reg <= 1'b0;
			end
			if (rx_done) begin
				rx_data_reg <= rx_shift_reg;
			end
		end
	end

	// ****************************************
	// Read path and outputs
	// ****************************************
	wire [SPMC_ST_W-1:0] status_view = status_reg | ({{(SPMC_ST_W-1){1'b0}}, ~tx_full_reg} << SPMC_ST_TXE);
	wire [31:0] rd_mux =
		addr_hit(reg_addr, SPMC_OFF_STATUS) ? {22'h000000, status_view} :
		addr_hit(reg_addr, SPMC_OFF_DATA) ? {24'h000000, rx_data_reg} :
		addr_hit(reg_addr, SPMC_OFF_BAUD) ? {16'h0000, baud_reg} :
		addr_hit(reg_addr, SPMC_OFF_CTRL1) ? {18'h00000, ctrl1_reg} :
		addr_hit(reg_addr, SPMC_OFF_CTRL2) ? {17'h00000, ctrl2_reg} :
		addr_hit(reg_addr, SPMC_OFF_CTRL3) ? {21'h000000, ctrl3_reg} :
		addr_hit(reg_addr, SPMC_OFF_GTPR) ? {16'h0000, gtpr_reg} :
		addr_hit(reg_addr, SPMC_OFF_MASK) ? {22'h000000, mask_reg} : 32'h00000000;

	wire cts_irq = ctrl3_reg.clear_to_send_irq_en & status_view[SPMC_ST_CTS];
	// error interrupt only with receive DMA
	wire err_irq = ctrl3_reg.error_irq_en & ctrl3_reg.rx_dma_en &
		(status_view[SPMC_ST_FE] | status_view[SPMC_ST_ORE] | status_view[SPMC_ST_NE]);
	wire irq_next = (|(status_view & mask_reg)) | cts_irq | err_irq;
	// request-to-send high while the receive word is unread
	wire rts_n_next = ctrl3_reg.request_to_send_flow_en & status_reg[SPMC_ST_RXNE];

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 32'h00000000;
			tx_pin_out <= 1'b1;
			tx_pin_oe_n <= 1'b0;
			request_to_send_out_n <= 1'b0;
			smartcard_clk_out <= 1'b0;
			tx_dma_req <= 1'b0;
			rx_dma_req <= 1'b0;
			irq <= 1'b0;
		end else begin
			reg_rdata <= reg_read ? rd_mux : 32'h00000000;
			tx_pin_out <= pin_level;
			tx_pin_oe_n <= pin_oe_n;
			request_to_send_out_n <= rts_n_next;
			smartcard_clk_out <= sc_clk_reg;
			tx_dma_req <= ctrl3_reg.tx_dma_en & ~tx_full_reg;
			rx_dma_req <= ctrl3_reg.rx_dma_en & status_reg[SPMC_ST_RXNE];
			irq <= irq_next;
		end
	end

endmodule

// >>> inc/spmc_pkg.sv
// Shared constants and types of the serial port mode control block.
// Assumes a 32-bit register port with word offsets and a single clock domain.
package spmc_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] SPMC_OFF_STATUS = 8'h00;
	localparam logic [7:0] SPMC_OFF_DATA = 8'h04;
	localparam logic [7:0] SPMC_OFF_BAUD = 8'h08;
	localparam logic [7:0] SPMC_OFF_CTRL1 = 8'h0c;
	localparam logic [7:0] SPMC_OFF_CTRL2 = 8'h10;
	localparam logic [7:0] SPMC_OFF_CTRL3 = 8'h14;
	localparam logic [7:0] SPMC_OFF_GTPR = 8'h18;
	localparam logic [7:0] SPMC_OFF_MASK = 8'h1c;

	// ****************************************
	// Status bit positions
	// ****************************************
	localparam int SPMC_ST_CTS = 9;
	localparam int SPMC_ST_TXE = 7;
	localparam int SPMC_ST_TC = 6;
	localparam int SPMC_ST_RXNE = 5;
	localparam int SPMC_ST_ORE = 3;
	localparam int SPMC_ST_NE = 2;
	localparam int SPMC_ST_FE = 1;
	localparam int SPMC_ST_PE = 0;
	localparam int SPMC_ST_W = 10;

	// ****************************************
	// Control one bit positions
	// ****************************************
	localparam int SPMC_C1_UE = 13;
	localparam int SPMC_C1_PCE = 10;
	localparam int SPMC_C1_PS = 9;
	localparam int SPMC_C1_TE = 3;
	localparam int SPMC_C1_RE = 2;

	// ****************************************
	// Widths and reset values
	// ****************************************
	localparam int SPMC_C1_W = 14;
	localparam int SPMC_C2_W = 15;
	localparam int SPMC_C3_W = 11;
	localparam int SPMC_DATA_BITS = 8;
	localparam logic [15:0] SPMC_GTPR_RST = 16'h0000;
	localparam logic [SPMC_ST_W-1:0] SPMC_STATUS_RST = 10'h040;
	localparam logic [17:0] SPMC_IR_PULSE_NUM = 18'h00003;
	localparam int SPMC_IR_PULSE_SHIFT = 4;

	// Third control register, bit 10 down to bit 0
	typedef struct packed {
		logic clear_to_send_irq_en;
		logic clear_to_send_flow_en;
		logic request_to_send_flow_en;
		logic tx_dma_en;
		logic rx_dma_en;
		logic smartcard_en;
		logic parity_nak_en;
		logic half_duplex_sel;
		logic infrared_low_power;
		logic infrared_en;
		logic error_irq_en;
	} spmc_ctrl3_type;

	// Guard time in the high byte, prescaler in the low byte
	typedef struct packed {
		logic [7:0] guard_time;
		logic [7:0] clock_prescale;
	} spmc_gtpr_type;

	typedef enum logic [2:0] {
		SPMC_TX_IDLE = 3'b000,
		SPMC_TX_START = 3'b001,
		SPMC_TX_DATA = 3'b010,
		SPMC_TX_PAR = 3'b011,
		SPMC_TX_STOP = 3'b100,
		SPMC_TX_GUARD = 3'b101
	} spmc_tx_state_type;

	typedef enum logic [2:0] {
		SPMC_RX_IDLE = 3'b000,
		SPMC_RX_START = 3'b001,
		SPMC_RX_DATA = 3'b010,
		SPMC_RX_PAR = 3'b011,
		SPMC_RX_STOP = 3'b100,
		SPMC_RX_NAK = 3'b101
	} spmc_rx_state_type;

endpackage

// >>> dv/spmc_chk.sv
// Port checker of the serial port mode control block.
// Assumes binding to spmc_top; shadows the few registers it needs.
`timescale 1ns/10ps

module spmc_chk
	import spmc_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic rx_pin_in,
	input wire logic tx_pin_in,
	input wire logic tx_pin_out,
	input wire logic tx_pin_oe_n,
	input wire logic clear_to_send_in_n,
	input wire logic request_to_send_out_n,
	input wire logic smartcard_clk_out,
	input wire logic tx_dma_req,
	input wire logic rx_dma_req,
	input wire logic irq
);
	spmc_ctrl3_type c3_reg;
	logic [15:0] gt_reg;
	logic [SPMC_ST_W-1:0] mask_reg;
	wire logic irq_src_off;
	wire logic pin_normal;

	// ****
	// Register shadows
	// ****
	assign irq_src_off = mask_reg == '0 && !c3_reg.clear_to_send_irq_en && !(c3_reg.error_irq_en && c3_reg.rx_dma_en);
	assign pin_normal = !c3_reg.half_duplex_sel && !c3_reg.smartcard_en;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			c3_reg <= '0;
			gt_reg <= '0;
			mask_reg <= '0;
		end else if (reg_write) begin
			if (reg_addr == SPMC_OFF_CTRL3) c3_reg <= reg_wdata[SPMC_C3_W-1:0];
			if (reg_addr == SPMC_OFF_GTPR) gt_reg <= reg_wdata[15:0];
			if (reg_addr == SPMC_OFF_MASK) mask_reg <= reg_wdata[SPMC_ST_W-1:0];
		end
	end

	// ****
	// Assertions
	// ****
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);

	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read cycle");
	ctrl3_read_a: assert property ($past(reg_read && reg_addr == SPMC_OFF_CTRL3) |->
		reg_rdata == {21'h0, $past(c3_reg)}) else $error("control three readback wrong");
	guard_read_a: assert property ($past(reg_read && reg_addr == SPMC_OFF_GTPR) |->
		reg_rdata == {16'h0, $past(gt_reg)}) else $error("guard prescale readback wrong");
	tx_dma_off_a: assert property (!c3_reg.tx_dma_en [*2] |-> !tx_dma_req)
		else $error("transmit request while disabled");
	rx_dma_off_a: assert property (!c3_reg.rx_dma_en && !$past(c3_reg.rx_dma_en) |-> !rx_dma_req)
		else $error("receive request while disabled");
	card_clk_off_a: assert property (!c3_reg.smartcard_en [*3] |-> !smartcard_clk_out)
		else $error("card clock outside smartcard mode");
	irq_gated_a: assert property (irq_src_off && $past(irq_src_off) |-> !irq)
		else $error("interrupt without enabled source");
	rts_free_a: assert property (!c3_reg.request_to_send_flow_en [*2] |-> !request_to_send_out_n)
		else $error("request to send high without flow control");
	pin_drive_a: assert property (pin_normal [*2] |-> !tx_pin_oe_n)
		else $error("transmit pin released in normal mode");

	cover property (irq ##1 !irq);
	cover property ($rose(tx_dma_req));
	cover property ($rose(rx_dma_req));
	cover property ($rose(smartcard_clk_out));
endmodule

bind spmc_top spmc_chk spmc_chk_i (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
	.rx_pin_in, .tx_pin_in, .tx_pin_out, .tx_pin_oe_n, .clear_to_send_in_n, .request_to_send_out_n,
	.smartcard_clk_out, .tx_dma_req, .rx_dma_req, .irq);

// >>> dv/spmc_peer.sv
// Remote serial transceiver with handshake lines.
// Assumes 8 data bits, no parity, one stop bit at a fixed bit length.
`timescale 1ns/10ps

module spmc_peer #(
	parameter int BIT_CYCLES = 8
) (
	input wire logic clock,
	input wire logic line_in,
	input wire logic rts_n,
	input wire logic cts_hold,
	output logic line_out,
	output logic cts_n
);
	logic [7:0] got;
	int frames;

	assign cts_n = cts_hold;
	initial begin
		line_out = 1'h1;
		got = 8'h00;
		frames = 0;
	end

	// ****
	// Frame capture
	// ****
	always begin
		@(negedge line_in);
		repeat (BIT_CYCLES / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge clock);
			got[i] = line_in;
		end
		repeat (BIT_CYCLES) @(posedge clock);
		frames++;
	end

	task automatic send(input logic [7:0] v, input logic stop);
		while (rts_n) @(posedge clock);
		line_out <= 1'h0;
		repeat (BIT_CYCLES) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			line_out <= v[i];
			repeat (BIT_CYCLES) @(posedge clock);
		end
		line_out <= stop;
		repeat (BIT_CYCLES) @(posedge clock);
		line_out <= 1'h1;
	endtask
endmodule

// >>> dv/spmc_top_test.sv
// Self-checking bench of the serial port mode control block.
// Assumes spmc_top, spmc_chk and spmc_peer are compiled before it.
`timescale 1ns/10ps

module spmc_top_test
	import spmc_pkg::*;
;
	localparam int BIT = 8;
	logic clock = 1'h0;
	logic arst_n = 1'h0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'h0;
	logic reg_read = 1'h0;
	logic cts_hold = 1'h0;
	logic [31:0] reg_rdata;
	logic rx_pin_in, clear_to_send_in_n, tx_pin_out, tx_pin_oe_n, request_to_send_out_n;
	logic smartcard_clk_out, tx_dma_req, rx_dma_req, irq;
	wire logic tx_pin_in;
	logic [31:0] seed = 32'h0d721b77;
	int mismatches = 0;
	int tests_run = 0;
	int n0, n1;

	// Pulled-up single wire driven only by the device
	assign tx_pin_in = tx_pin_oe_n ? 1'h1 : tx_pin_out;
	always #50 clock = ~clock;

	spmc_top spmc_top_i (.clock, .arst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .rx_pin_in,
		.tx_pin_in, .tx_pin_out, .tx_pin_oe_n, .clear_to_send_in_n, .request_to_send_out_n, .smartcard_clk_out,
		.tx_dma_req, .rx_dma_req, .irq);
	spmc_peer #(.BIT_CYCLES(BIT)) spmc_peer_i (.clock, .line_in(tx_pin_out), .rts_n(request_to_send_out_n),
		.cts_hold, .line_out(rx_pin_in), .cts_n(clear_to_send_in_n));

	// ****
	// Helpers
	// ****
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [31:0] card_edges(input logic [7:0] psc, input int span);
		return span / psc[4:0];
	endfunction

	function automatic logic [31:0] ir_high(input logic [7:0] psc, input logic [7:0] v);
		return 3 * psc * (9 - $countones(v));
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'h1;
		@(posedge clock);
		reg_write <= 1'h0;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'h1;
		@(posedge clock);
		reg_read <= 1'h0;
		@(negedge clock);
		chk(reg_rdata, e);
	endtask

	task automatic settle;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic wait_start;
		for (int i = 0; i < 100 && tx_pin_out; i++) @(posedge clock);
	endtask

	task automatic wait_frame(input int n);
		for (int i = 0; i < 400 && spmc_peer_i.frames < n; i++) @(posedge clock);
		chk(spmc_peer_i.frames, n);
	endtask

	task automatic watch(input int span, output int hi, output int ed);
		logic last;
		hi = 0;
		ed = 0;
		last = smartcard_clk_out;
		repeat (span) begin
			@(negedge clock);
			hi += tx_pin_out;
			ed += (smartcard_clk_out != last);
			last = smartcard_clk_out;
		end
	endtask

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****
	// Scenarios
	// ****
	initial begin
		repeat (6) @(posedge clock);
		arst_n <= 1'h1;
		for (int a = 0; a <= 32; a += 4) rc(8'(a), a == 0 ? 32'h0c0 : 32'h0);
		wr(SPMC_OFF_MASK, 32'h40);
		settle;
		chk(32'(irq), 32'h1);
		wr(SPMC_OFF_MASK, 32'h0);
		settle;
		chk(32'(irq), 32'h0);
		wr(SPMC_OFF_MASK, 32'h40);
		wr(SPMC_OFF_STATUS, 32'h40);
		settle;
		chk(32'(irq), 32'h0);
		wr(SPMC_OFF_MASK, 32'h0);
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			wr(SPMC_OFF_GTPR, seed | 32'h1);
			rc(SPMC_OFF_GTPR, {16'h0, seed[15:1], 1'h1});
			wr(SPMC_OFF_CTRL3, seed);
			rc(SPMC_OFF_CTRL3, {21'h0, seed[10:0]});
			wr(8'h20, seed);
			rc(8'h20, 32'h0);
		end
		wr(SPMC_OFF_CTRL3, 32'h0);
		repeat (100) @(posedge clock);
		wr(SPMC_OFF_STATUS, 32'h3ff);
		wr(SPMC_OFF_BAUD, BIT);
		wr(SPMC_OFF_CTRL1, 32'h200c);
		cts_hold <= 1'h1;
		wr(SPMC_OFF_CTRL3, 32'h300);
		n0 = spmc_peer_i.frames;
		seed = lfsr(seed);
		wr(SPMC_OFF_DATA, {24'h0, seed[7:0]});
		repeat (60) @(posedge clock);
		settle;
		chk(spmc_peer_i.frames, n0);
		chk(32'(tx_pin_out), 32'h1);
		@(posedge clock);
		cts_hold <= 1'h0;
		wait_frame(n0 + 1);
		chk(32'(spmc_peer_i.got), {24'h0, seed[7:0]});
		seed = lfsr(seed);
		wr(SPMC_OFF_DATA, {24'h0, seed[7:0]});
		wait_start;
		cts_hold <= 1'h1;
		wr(SPMC_OFF_DATA, {24'h0, ~seed[7:0]});
		wait_frame(n0 + 2);
		chk(32'(spmc_peer_i.got), {24'h0, seed[7:0]});
		repeat (120) @(posedge clock);
		chk(spmc_peer_i.frames, n0 + 2);
		cts_hold <= 1'h0;
		wait_frame(n0 + 3);
		chk(32'(spmc_peer_i.got), {24'h0, ~seed[7:0]});
		wr(SPMC_OFF_CTRL3, 32'h700);
		settle;
		chk(32'(irq), 32'h1);
		wr(SPMC_OFF_CTRL3, 32'h300);
		settle;
		chk(32'(irq), 32'h0);
		wr(SPMC_OFF_STATUS, 32'h200);
		wr(SPMC_OFF_CTRL3, 32'h380);
		settle;
		chk(32'(tx_dma_req), 32'h1);
		wr(SPMC_OFF_CTRL3, 32'h340);
		seed = lfsr(seed);
		spmc_peer_i.send(seed[7:0], 1'h1);
		settle;
		chk(32'(tx_dma_req), 32'h0);
		chk(32'(request_to_send_out_n), 32'h1);
		chk(32'(rx_dma_req), 32'h1);
		rc(SPMC_OFF_DATA, {24'h0, seed[7:0]});
		settle;
		chk(32'(request_to_send_out_n), 32'h0);
		chk(32'(rx_dma_req), 32'h0);
		wr(SPMC_OFF_CTRL3, 32'h041);
		spmc_peer_i.send(8'h5a, 1'h0);
		settle;
		chk(32'(irq), 32'h1);
		wr(SPMC_OFF_CTRL3, 32'h001);
		settle;
		chk(32'(irq), 32'h0);
		repeat (100) @(posedge clock);
		wr(SPMC_OFF_STATUS, 32'h3ff);
		wr(SPMC_OFF_GTPR, 32'h00e3);
		wr(SPMC_OFF_CTRL3, 32'h020);
		settle;
		watch(60, n1, n0);
		chk(n0, card_edges(8'he3, 60));
		wr(SPMC_OFF_CTRL3, 32'h008);
		settle;
		chk(32'(tx_pin_oe_n), 32'h1);
		n0 = spmc_peer_i.frames;
		wr(SPMC_OFF_DATA, 32'h0f);
		wait_start;
		settle;
		chk(32'(tx_pin_oe_n), 32'h0);
		wait_frame(n0 + 1);
		repeat (20) @(posedge clock);
		wr(SPMC_OFF_GTPR, 32'h0001);
		wr(SPMC_OFF_CTRL3, 32'h002);
		settle;
		chk(32'(tx_pin_out), 32'h0);
		wr(SPMC_OFF_GTPR, 32'h0002);
		wr(SPMC_OFF_CTRL3, 32'h006);
		seed = lfsr(seed);
		wr(SPMC_OFF_DATA, {24'h0, seed[7:0]});
		watch(150, n1, n0);
		chk(n1, ir_high(8'h02, seed[7:0]));
		final_report;
	end

	initial begin
		#2000000;
		mismatches++;
		final_report;
	end
endmodule
